// [hdl/rmc_params.svh]
/*
 * Constants of the registered magnitude comparator: widths, depths,
 * select codes and reset values.
 * Assumes it is included by bare name from hdl/ files only.
 */
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH

// data path
`define RMC_WIDTH       8
`define RMC_MSB         7
`define RMC_FIFO_DEPTH  16

// select codes {mode_pick_high, mode_pick_low}
`define RMC_SEL_HOLD    2'h0
`define RMC_SEL_SHIFT   2'h1
`define RMC_SEL_OUT     2'h3
`define RMC_SEL_LOAD    2'h2

// reset values
`define RMC_REG_RST     8'h00
`define RMC_FLAG_OFF    3'h7
`define RMC_FLAG_LOW    3'h0

`endif

// [hdl/rmc_pkg.sv]
/*
 * Types of the registered magnitude comparator.
 * Assumes rmc_params.svh is on the include path.
 */
`include "rmc_params.svh"

package rmc_pkg;

    // operating modes, gray ordered hold-shift-output-load
    typedef enum logic [1:0] {
        mode_hold  = `RMC_SEL_HOLD,
        mode_shift = `RMC_SEL_SHIFT,
        mode_out   = `RMC_SEL_OUT,
        mode_load  = `RMC_SEL_LOAD
    } rmc_mode_t;

    // three open-collector status lines
    typedef struct packed {
        logic greater_flag;
        logic below_flag;
        logic match_flag;
    } rmc_flag_t;

    // every asynchronous input, synchronised as one word
    typedef struct packed {
        logic [`RMC_MSB:0] bus;
        logic              mode_pick_high;
        logic              mode_pick_low;
        logic              serial_in;
        logic              status_gate_n;
        logic              signed_mode;
        rmc_flag_t         flags;
    } rmc_pins_t;

endpackage

// [hdl/rmc_fifo.sv]
/*
 * Parameterised synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, asynchronous active-low reset, DEPTH a power of 2.
 */
`timescale 1ns/1ps
`include "rmc_params.svh"

module rmc_fifo #(
    parameter int WIDTH = `RMC_WIDTH,
    parameter int DEPTH = `RMC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            case ({push, pop})
                2'h2:    cnt_r <= cnt_r + 1'b1;
                2'h1:    cnt_r <= cnt_r - 1'b1;
                default: cnt_r <= cnt_r;
            endcase
        end
    end

endmodule

// [hdl/rmc_top.sv]
/*
 * Registered magnitude comparator: an 8-bit register on shared
 * two-way data pins, a comparator between register and pins, serial
 * link pins for shifting and cascading, open-collector status lines.
 * Assumes every pin input is asynchronous to clock; the board resolves
 * the two-way and wired-AND lines from the output enables.
 */
`timescale 1ns/1ps
`include "rmc_params.svh"

module rmc_top (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rstn,
    // shared data pins
    input  wire logic [`RMC_MSB:0]  bus_in,
    output logic      [`RMC_MSB:0]  bus_out,
    output logic                    bus_oe_n,
    // mode selection
    input  wire logic               mode_pick_low,
    input  wire logic               mode_pick_high,
    input  wire logic               signed_mode,
    // serial and cascade link
    input  wire logic               serial_in,
    output logic                    serial_out,
    // status lines
    input  wire logic               status_gate_n,
    input  wire rmc_pkg::rmc_flag_t flags_in,
    output rmc_pkg::rmc_flag_t      flags_out,
    output rmc_pkg::rmc_flag_t      flags_oe_n,
    output rmc_pkg::rmc_flag_t      flags_seen,
    // load queue
    output logic                    load_ready
);

    ////////////////////////////////////////////////////////////////////
    // comparator

    function automatic rmc_pkg::rmc_flag_t compare(
        input logic [`RMC_MSB:0] a,
        input logic [`RMC_MSB:0] b,
        input logic              sgn
    );
        logic [`RMC_MSB:0] ax;
        logic [`RMC_MSB:0] bx;
        rmc_pkg::rmc_flag_t r;
        ax = a;
        bx = b;
        ax[`RMC_MSB] = a[`RMC_MSB] ^ sgn;
        bx[`RMC_MSB] = b[`RMC_MSB] ^ sgn;
        r.greater_flag = (ax > bx);
        r.below_flag   = (ax < bx);
        r.match_flag   = (ax == bx);
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // input synchroniser

    rmc_pkg::rmc_pins_t pins_raw;
    rmc_pkg::rmc_pins_t s1_r;
    rmc_pkg::rmc_pins_t s2_r;

    always_comb begin
        pins_raw.bus            = bus_in;
        pins_raw.mode_pick_high = mode_pick_high;
        pins_raw.mode_pick_low  = mode_pick_low;
        pins_raw.serial_in      = serial_in;
        pins_raw.status_gate_n  = status_gate_n;
        pins_raw.signed_mode    = signed_mode;
        pins_raw.flags          = flags_in;
    end

    // first stage feeds only the second
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= pins_raw;
            s2_r <= s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode decode

    rmc_pkg::rmc_mode_t mode;
    logic               shifting;
    logic               cascade_in;
    rmc_pkg::rmc_flag_t result;

    assign mode = rmc_pkg::rmc_mode_t'({s2_r.mode_pick_high,
                                        s2_r.mode_pick_low});
    assign shifting   = (mode == rmc_pkg::mode_shift);
    assign cascade_in = s2_r.serial_in & ~shifting;

    logic [`RMC_MSB:0] reg_r;

    assign result = compare(reg_r, s2_r.bus, s2_r.signed_mode);

    ////////////////////////////////////////////////////////////////////
    // load queue

    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic [`RMC_MSB:0] fifo_out_data;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic              pop;

    // words sampled in load mode drain on the next cycle whatever the
    // mode, so no word is left over for a later load to apply again;
    // a word that drains while shifting is dropped
    assign fifo_in_valid  = (mode == rmc_pkg::mode_load);
    assign fifo_out_ready = 1'b1;
    assign pop            = fifo_out_valid & fifo_out_ready;

    rmc_fifo #(
        .WIDTH (`RMC_WIDTH),
        .DEPTH (`RMC_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .in_data   (s2_r.bus),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready)
    );

    logic load_ready_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            load_ready_r <= 1'b0;
        end else begin
            load_ready_r <= fifo_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data register

    logic [`RMC_MSB:0] reg_nxt;

    always_comb begin
        reg_nxt = reg_r;
        case (mode)
            rmc_pkg::mode_shift: reg_nxt = {s2_r.serial_in,
                                            reg_r[`RMC_MSB:1]};
            // parallel load from the queue, two cycles behind the synchronised pins
            default: begin
                if (pop) begin
                    reg_nxt = fifo_out_data;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_r <= `RMC_REG_RST;
        end else begin
            reg_r <= reg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data pins

    logic [`RMC_MSB:0] bus_out_r;
    logic              bus_oe_n_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_out_r  <= `RMC_REG_RST;
            bus_oe_n_r <= 1'b1;
        end else begin
            bus_out_r  <= reg_nxt;
            bus_oe_n_r <= (mode != rmc_pkg::mode_out);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // serial and cascade link

    logic serial_out_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            serial_out_r <= 1'b0;
        end else if (shifting) begin
            serial_out_r <= reg_nxt[0];
        end else begin
            serial_out_r <= cascade_in | ~result.match_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status lines

    rmc_pkg::rmc_flag_t flags_oe_n_r;
    rmc_pkg::rmc_flag_t flags_seen_r;
    logic               release_all;

    assign release_all = s2_r.status_gate_n | cascade_in;

    // true flag floats high, false pulled low
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_oe_n_r <= `RMC_FLAG_OFF;
        end else if (release_all) begin
            flags_oe_n_r <= `RMC_FLAG_OFF;
        end else begin
            flags_oe_n_r <= result;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_seen_r <= `RMC_FLAG_LOW;
        end else begin
            flags_seen_r <= s2_r.flags;
        end
    end

    assign bus_out    = bus_out_r;
    assign bus_oe_n   = bus_oe_n_r;
    assign serial_out = serial_out_r;
    assign flags_out  = `RMC_FLAG_LOW;
    assign flags_oe_n = flags_oe_n_r;
    assign flags_seen = flags_seen_r;
    assign load_ready = load_ready_r;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence s_push_empty;
        fifo_in_valid && fifo_in_ready && !fifo_out_valid;
    endsequence

    sequence s_load_word;
        s_push_empty ##1 (pop && !shifting);
    endsequence

    a_load_lands: assert property (
        s_load_word |=> reg_r == $past(s2_r.bus, 2)
    ) else $error("loaded word differs from pins");

    a_shift_lsb: assert property (
        shifting |=> reg_r == {$past(s2_r.serial_in),
                               $past(reg_r[`RMC_MSB:1])}
                     && serial_out == reg_r[0]
    ) else $error("shift did not move lsb first");

    a_hold_keeps: assert property (
        mode == rmc_pkg::mode_hold |=>
            reg_r == ($past(pop) ? $past(fifo_out_data) : $past(reg_r))
    ) else $error("register changed in hold");

    a_out_drives: assert property (
        mode == rmc_pkg::mode_out |=> !bus_oe_n && bus_out == reg_r
    ) else $error("output mode not driving register");

    a_gate_off: assert property (
        s2_r.status_gate_n |=> flags_oe_n == `RMC_FLAG_OFF
    ) else $error("status gate did not release flags");

    a_upper_wins: assert property (
        cascade_in |=> flags_oe_n == `RMC_FLAG_OFF && serial_out
    ) else $error("upper package did not take priority");

    a_match_flag: assert property (
        !release_all |=> flags_oe_n.match_flag ==
                         ($past(reg_r) == $past(s2_r.bus))
    ) else $error("match flag wrong");

    a_signed_cmp: assert property (
        !release_all && s2_r.signed_mode |=>
            flags_oe_n.greater_flag ==
            ($signed($past(reg_r)) > $signed($past(s2_r.bus)))
    ) else $error("signed compare wrong");

    a_cascade_out: assert property (
        !shifting && !s2_r.serial_in && reg_r != s2_r.bus |=>
            serial_out ##1 1'b1
    ) else $error("cascade out not raised on mismatch");

endmodule

// [tb/rmc_far_model.sv]
/* Far side of the comparator: shared data pins and one peer package
   on the wired status lines.
   Assumes the bench says when the far side drives the data pins. */
`timescale 1ns/1ps

module rmc_far_model (
    // clock
    input  wire logic               clock,
    // data pins
    input  wire logic [7:0]         far_data,
    input  wire logic               far_drive,
    input  wire logic [7:0]         bus_out,
    input  wire logic               bus_oe_n,
    output logic      [7:0]         bus_wire,
    // status lines
    input  wire rmc_pkg::rmc_flag_t flags_out,
    input  wire rmc_pkg::rmc_flag_t flags_oe_n,
    input  wire rmc_pkg::rmc_flag_t peer_oe_n,
    output rmc_pkg::rmc_flag_t      flags_wire
);
    logic [7:0] last_r = 8'h00;

    ////////////////////////////////////////////////////////////////////
    // shared data pins
    // floating pins flip every cycle, two drivers give unknown
    always_comb begin
        if (!bus_oe_n && far_drive) bus_wire = 8'hxx;
        else if (!bus_oe_n) bus_wire = bus_out;
        else if (far_drive) bus_wire = far_data;
        else bus_wire = ~last_r;
    end

    always_ff @(posedge clock) last_r <= bus_wire;

    ////////////////////////////////////////////////////////////////////
    // wired-AND lines
    // pulled up, low while any package pulls the line down
    assign flags_wire = (flags_oe_n | flags_out) & peer_oe_n;
endmodule

// [tb/tb_rmc_top.sv]
/* Self-checking bench of the registered magnitude comparator and its
   load queue. Assumes rmc_pkg and the far side model are compiled. */
`timescale 1ns/1ps

module tb_rmc_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] far_data = 8'h00;
    logic far_drive = 1'b0;
    logic [1:0] sel = 2'h0;
    logic signed_mode = 1'b0;
    logic serial_in = 1'b0;
    logic status_gate_n = 1'b0;
    rmc_pkg::rmc_flag_t peer_oe_n = 3'h7;
    logic [7:0] bus_wire, bus_out, cur;
    logic bus_oe_n, serial_out, load_ready;
    rmc_pkg::rmc_flag_t flags_wire, flags_out, flags_oe_n, flags_seen;
    int fail_count = 0;
    int samples_checked = 0;
    integer seed = 36;

    always #25 clock = ~clock;

    rmc_top dut (.clock(clock), .rstn(rstn), .bus_in(bus_wire),
        .bus_out(bus_out), .bus_oe_n(bus_oe_n), .mode_pick_low(sel[0]),
        .mode_pick_high(sel[1]), .signed_mode(signed_mode),
        .serial_in(serial_in), .serial_out(serial_out),
        .status_gate_n(status_gate_n), .flags_in(flags_wire),
        .flags_out(flags_out), .flags_oe_n(flags_oe_n),
        .flags_seen(flags_seen), .load_ready(load_ready));
    rmc_far_model far (.clock(clock), .far_data(far_data),
        .far_drive(far_drive), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
        .bus_wire(bus_wire), .flags_out(flags_out),
        .flags_oe_n(flags_oe_n), .peer_oe_n(peer_oe_n),
        .flags_wire(flags_wire));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [2:0] cmp_exp(input logic [7:0] r, x,
                                           input logic sgn);
        logic [7:0] a;
        logic [7:0] b;
        a = r ^ {sgn, 7'h00};
        b = x ^ {sgn, 7'h00};
        return {a > b, a < b, a == b};
    endfunction

    task automatic settle();
        repeat (6) @(posedge clock);
        #1;
    endtask

    // parallel output shows the register
    task automatic show_reg(input logic [7:0] d);
        @(posedge clock);
        sel <= 2'h3;
        far_drive <= 1'b0;
        serial_in <= 1'b0;
        settle();
        check("bus_oe_n", 8'h00, {7'h00, bus_oe_n});
        check("bus_out", d, bus_out);
    endtask

    task automatic compare(input logic [7:0] d, x,
                           input logic sgn, gate, casc);
        logic [2:0] e;
        // pins released by the device before the far side drives them
        @(posedge clock);
        sel <= 2'h0;
        far_drive <= 1'b0;
        settle();
        @(posedge clock);
        sel <= 2'h2;
        far_drive <= 1'b1;
        far_data <= d;
        settle();
        show_reg(d);
        @(posedge clock);
        sel <= 2'h0;
        signed_mode <= sgn;
        status_gate_n <= gate;
        serial_in <= casc;
        peer_oe_n <= 3'($random(seed));
        settle();
        @(posedge clock);
        far_data <= x;
        far_drive <= 1'b1;
        settle();
        e = (gate | casc) ? 3'h7 : cmp_exp(d, x, sgn);
        check("flags_oe_n", {5'h00, e}, {5'h00, flags_oe_n});
        check("serial_out", {7'h00, casc | (d != x)}, {7'h00, serial_out});
        check("flags_seen", {5'h00, e & peer_oe_n}, {5'h00, flags_seen});
        check("flags_out", 8'h00, {5'h00, flags_out});
        show_reg(d);
        cur = d;
    endtask

    // serial entry, bits leave LSB first
    task automatic shift_in(input logic [7:0] bits);
        logic [15:0] v;
        v = {bits, cur};
        for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            sel <= (i < 8) ? 2'h1 : 2'h0;
            serial_in <= (i < 8) ? bits[i] : 1'b0;
            #1;
            if (i >= 3 && i <= 10)
                check("shift out", {7'h00, v[i-2]}, {7'h00, serial_out});
        end
        show_reg(bits);
        cur = bits;
    endtask

    // load queue through the pins: a word per cycle, then a one-cycle load
    task automatic load_burst();
        logic [7:0] w;
        w = 8'h00;
        @(posedge clock);
        sel <= 2'h0;
        far_drive <= 1'b0;
        settle();
        for (int k = 0; k < 20; k++) begin
            @(posedge clock);
            w = 8'($random(seed));
            sel <= 2'h2;
            far_drive <= 1'b1;
            far_data <= w;
        end
        @(posedge clock);
        sel <= 2'h0;
        settle();
        check("load_ready", 8'h01, {7'h00, load_ready});
        show_reg(w);
        w = ~w;
        @(posedge clock);
        sel <= 2'h0;
        settle();
        @(posedge clock);
        sel <= 2'h2;
        far_drive <= 1'b1;
        far_data <= w;
        @(posedge clock);
        sel <= 2'h0;
        settle();
        show_reg(w);
        cur = w;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        cur = 8'h00;
        repeat (3) @(posedge clock);
        #1;
        check("reset oe", 8'h01, {7'h00, bus_oe_n});
        check("reset flags", 8'h07, {5'h00, flags_oe_n});
        repeat (9) @(posedge clock);
        rstn <= 1'b1;
        settle();
        check("load_ready", 8'h01, {7'h00, load_ready});
        compare(8'h7f, 8'h80, 1'b0, 1'b0, 1'b0);
        compare(8'h7f, 8'h80, 1'b1, 1'b0, 1'b0);
        compare(8'h5a, 8'h5a, 1'b0, 1'b0, 1'b0);
        compare(8'h00, 8'hff, 1'b0, 1'b1, 1'b0);
        compare(8'hff, 8'h00, 1'b1, 1'b0, 1'b1);
        for (int n = 0; n < 16; n++) begin
            compare(8'($random(seed)), 8'($random(seed)), 1'($random(seed)),
                    ($random(seed) % 4) == 0, ($random(seed) % 4) == 0);
            shift_in(8'($random(seed)));
        end
        shift_in(8'h01);
        load_burst();
        give_verdict();
    end

    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        give_verdict();
    end
endmodule
